/* shared/jrxcfg_pkg.sv */
// constants for the serial receiver link configuration register slice
// assumes an 8-bit register port with a 12-bit address

package jrxcfg_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam logic [11:0] ADDR_TERM_CAL_B = 12'h2AE;
  localparam logic [11:0] ADDR_TERM_SET_A = 12'h2B1;
  localparam logic [11:0] ADDR_TERM_SET_B = 12'h2B2;
  localparam logic [11:0] ADDR_GEN_CTRL   = 12'h300;
  localparam logic [11:0] ADDR_CFG_FIRST  = 12'h400;
  localparam logic [11:0] ADDR_CFG_LAST   = 12'h40A;
  localparam logic [11:0] ADDR_CSUM_FIRST = 12'h40E;
  localparam logic [11:0] ADDR_CSUM_STEP  = 12'h008;
  localparam int          CSUM_LANES      = 8;
  localparam int          CFG_BYTES       = 11;
  localparam int          LINKS           = 2;

  // ------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------
  localparam int          CAL_TRIG_BIT    = 0;
  localparam logic [7:0]  TERM_CAL_MASK   = 8'h01;
  localparam logic [7:0]  GEN_CTRL_MASK   = 8'h4F;
  localparam int          CSUM_MODE_BIT   = 6;
  localparam int          LINK_DUAL_BIT   = 3;
  localparam int          PAGE_SEL_BIT    = 2;
  localparam int          LINK_EN_LSB     = 0;
  localparam int          LINK_EN_MSB     = 1;
  localparam logic [7:0]  TERM_CAL_RESET  = 8'h00;
  localparam logic [7:0]  TERM_SET_A_RST  = 8'hC3;
  localparam logic [7:0]  TERM_SET_B_RST  = 8'h93;
  localparam logic [7:0]  GEN_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [7:0]  CAL_LANE_MASK   = 8'h3C; // lanes 2..5
  localparam logic [7:0]  CAL_TARGET_OHM  = 8'h32; // 50 ohm target

  // ------------------------------------------------------------
  // link parameter fields: octet, mask and shift of each
  // ------------------------------------------------------------
  localparam int          NUM_FIELDS      = 19;
  localparam logic [3:0]  FLD_OCTET [0:18] = '{
    4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5,
    4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA};
  localparam logic [7:0]  FLD_MASK  [0:18] = '{
    8'hFF, 8'h0F, 8'hF0, 8'h1F, 8'h20, 8'h40, 8'h1F, 8'h80, 8'hFF,
    8'h1F, 8'hFF, 8'h1F, 8'hC0, 8'h1F, 8'hE0, 8'h1F, 8'hE0, 8'h1F,
    8'h80};
  localparam logic [2:0]  FLD_SHIFT [0:18] = '{
    3'h0, 3'h0, 3'h4, 3'h0, 3'h5, 3'h6, 3'h0, 3'h7, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h6, 3'h0, 3'h5, 3'h0, 3'h5, 3'h0, 3'h7};

endpackage : jrxcfg_pkg

/* verification/jrxcfg_host.sv */
// host software model that drives the register port
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
module jrxcfg_host
(
  // clock
  input  wire logic        ref_clk,
  // register port, host side
  output      logic [11:0] reg_addr,
  output      logic [7:0]  reg_wdata,
  output      logic        reg_wr,
  output      logic        reg_rd,
  input  wire logic [7:0]  reg_rdata
);
  // strobes low from time zero
  initial
  begin
    reg_addr  = 12'h000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one-cycle write; data inverted after so nothing leans on a stale hold
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // one-cycle read, data taken in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // settings first, then calibration, link enables last
  task automatic bring_up;
    wr(12'h2B1, 8'hB7);
    wr(12'h2B2, 8'h87);
    wr(12'h2AE, 8'h01);
    wr(12'h300, 8'h03);
  endtask : bring_up
endmodule : jrxcfg_host

/* verification/jrxcfg_props.sv */
// assertions on the ports of the link configuration register bank
// assumes it is bound onto jrxcfg_regs and sees only its ports
`timescale 1ns/10ps
module jrxcfg_props
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_rdata,
  // control outputs
  input  wire logic        term_cal_start,
  input  wire logic [7:0]  term_cal_lanes,
  input  wire logic [7:0]  term_cal_target,
  input  wire logic [7:0]  term_setting_a,
  input  wire logic [7:0]  term_setting_b,
  input  wire logic        checksum_by_octets,
  input  wire logic        link_dual,
  input  wire logic        map_page_sel,
  input  wire logic [1:0]  link_enable
);
  logic cal_q;
  logic wr_cal;
  logic wr_ctl;
  // decoded writes
  assign wr_cal = reg_wr && reg_addr == 12'h2AE;
  assign wr_ctl = reg_wr && reg_addr == 12'h300;
  // shadow of the stored trigger bit, so the edge can be predicted
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) cal_q <= 1'b0;
    else if (wr_cal) cal_q <= reg_wdata[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_cal_edge_pulse: assert property (
    wr_cal && reg_wdata[0] && !cal_q |->
      ##2 term_cal_start ##1 !term_cal_start)
    else $error("calibration pulse missing");
  a_cal_no_spurious: assert property (
    term_cal_start |-> $past(cal_q) && !$past(cal_q, 2))
    else $error("calibration pulse without rising trigger");
  a_cal_lane_target: assert property (
    term_cal_start |-> term_cal_lanes == 8'h3C && term_cal_target == 8'h32)
    else $error("calibration lanes or target wrong");
  a_set_a_write: assert property (
    reg_wr && reg_addr == 12'h2B1 |=> term_setting_a == $past(reg_wdata))
    else $error("setting a not updated");
  a_set_b_write: assert property (
    reg_wr && reg_addr == 12'h2B2 |=> term_setting_b == $past(reg_wdata))
    else $error("setting b not updated");
  a_mode_bit_write: assert property (
    wr_ctl |=> checksum_by_octets == $past(reg_wdata[6]))
    else $error("checksum method bit wrong");
  a_dual_bit_write: assert property (
    wr_ctl |=> link_dual == $past(reg_wdata[3]))
    else $error("link count bit wrong");
  a_page_bit_write: assert property (
    wr_ctl |=> map_page_sel == $past(reg_wdata[2]))
    else $error("page select bit wrong");
  a_link_en_write: assert property (
    wr_ctl |=> link_enable == $past(reg_wdata[1:0]))
    else $error("link enables wrong");
  a_rsvd_read_zero: assert property (
    reg_rd && reg_addr == 12'h2AE |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved trigger bits not zero");
endmodule : jrxcfg_props
bind jrxcfg_regs jrxcfg_props jrxcfg_props_inst (.ref_clk(ref_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .term_cal_start(term_cal_start), .term_cal_lanes(term_cal_lanes),
  .term_cal_target(term_cal_target), .term_setting_a(term_setting_a),
  .term_setting_b(term_setting_b), .checksum_by_octets(checksum_by_octets),
  .link_dual(link_dual), .map_page_sel(map_page_sel),
  .link_enable(link_enable));

/* verification/serial_rx_link_config_regs_bench.sv */
// self-checking bench for the link configuration register bank
// assumes the host model drives the port and the checker is bound
`timescale 1ns/10ps
module serial_rx_link_config_regs_bench;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} jrxcfg_row_t;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, lanes, target, set_a, set_b, v, s0;
  logic        reg_wr, reg_rd, cal_start, by_oct, dual, page;
  logic [1:0]  link_en;
  logic [7:0]  oct [0:10];
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  int          fails = 0;
  int          n_tests = 0;
  int          pulses = 0;
  jrxcfg_row_t rows [0:7] = '{'{12'h2B1, 8'hB7, 8'hB7},
    '{12'h2B2, 8'h87, 8'h87}, '{12'h300, 8'hFF, 8'h4F},
    '{12'h300, 8'hB0, 8'h00}, '{12'h2AE, 8'hFE, 8'h00},
    '{12'h2AE, 8'h01, 8'h01}, '{12'h123, 8'hA5, 8'h00},
    '{12'h40E, 8'h77, 8'h00}};
  // clock and pulse counter, counted away from the launching edge
  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (cal_start === 1'b1) pulses++;
  jrxcfg_regs jrxcfg_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_cal_start(cal_start),
    .term_cal_lanes(lanes), .term_cal_target(target),
    .term_setting_a(set_a), .term_setting_b(set_b),
    .checksum_by_octets(by_oct), .link_dual(dual),
    .map_page_sel(page), .link_enable(link_en));
  jrxcfg_host jrxcfg_host_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, string n);
    jrxcfg_host_inst.rd(a, v);
    chk(n, e, v);
  endtask : rdchk
  // expected sum: octet sum or field sum, both modulo 256
  function automatic logic [7:0] sum_exp(input logic m);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < jrxcfg_pkg::CFG_BYTES; i++) if (m) s += oct[i];
    for (int f = 0; f < jrxcfg_pkg::NUM_FIELDS; f++)
      if (!m) s += (oct[jrxcfg_pkg::FLD_OCTET[f]] & jrxcfg_pkg::FLD_MASK[f])
        >> jrxcfg_pkg::FLD_SHIFT[f];
    return s;
  endfunction : sum_exp
  task automatic load(input logic [7:0] seed);
    for (int i = 0; i < 11; i++)
    begin
      oct[i] = 8'(seed * (i + 1));
      jrxcfg_host_inst.wr(12'h400 + 12'(i), oct[i]);
    end
  endtask : load
  task automatic close_out;
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // watchdog at 12500 cycles, far beyond the under 200 cycles the tests need
  initial
  begin
    #100000;
    fails++;
    close_out();
  end
  // reset values, table, then checksum, paging and calibration cases
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(12'h2AE, 8'h00, "cal_ctrl");
    rdchk(12'h2B1, 8'hC3, "set_a");
    rdchk(12'h2B2, 8'h93, "set_b");
    rdchk(12'h300, 8'h00, "gen_ctrl");
    foreach (rows[i])
    begin
      jrxcfg_host_inst.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e, "row");
    end
    chk("lanes", 8'h3C, lanes);
    chk("target", 8'h32, target);
    jrxcfg_host_inst.wr(12'h2AE, 8'h01);
    jrxcfg_host_inst.wr(12'h2AE, 8'h00);
    jrxcfg_host_inst.wr(12'h2AE, 8'h01);
    jrxcfg_host_inst.wr(12'h300, 8'h40);
    load(8'h1D);
    s0 = sum_exp(1'b1);
    rdchk(12'h40E, s0, "sum_oct");
    jrxcfg_host_inst.wr(12'h300, 8'h00);
    rdchk(12'h446, sum_exp(1'b0), "sum_fld");
    jrxcfg_host_inst.wr(12'h300, 8'h4C);
    load(8'h35);
    chk("pins", 8'h1C, {3'h0, by_oct, dual, page, link_en});
    rdchk(12'h436, sum_exp(1'b1), "sum_pg1");
    rdchk(12'h40A, oct[10], "oct_pg1");
    jrxcfg_host_inst.wr(12'h300, 8'h40);
    rdchk(12'h41E, s0, "sum_pg0");
    jrxcfg_host_inst.wr(12'h2AE, 8'h00);
    jrxcfg_host_inst.bring_up();
    // the last write lands on this edge; look once the flops have settled
    @(negedge ref_clk);
    chk("link_en", 8'h03, {6'h00, link_en});
    chk("set_a_pin", 8'hB7, set_a);
    chk("set_b_pin", 8'h87, set_b);
    repeat (3) @(posedge ref_clk);
    chk("pulses", 8'h03, 8'(pulses));
    close_out();
  end
endmodule : serial_rx_link_config_regs_bench

/* verilog/jrxcfg_csum.sv */
// link parameter checksum over one link's eleven configuration octets
// assumes the octets are held stable by the register bank around it

`timescale 1ns/10ps

module jrxcfg_csum
(
  // configuration octets, octet 0 in the low byte
  input  wire logic [87:0] cfg_octets,
  // method select and result
  input  wire logic        by_octets,
  output      logic [7:0]  csum
);

  // ------------------------------------------------------------
  // checksum arithmetic
  // ------------------------------------------------------------

  // pick one octet out of the packed vector
  function automatic logic [7:0] octet_at(input logic [87:0] v,
                                          input logic [3:0]  idx);
    octet_at = v[idx*8 +: 8];
  endfunction : octet_at

  // both sums wrap at 256 by the 8-bit accumulator
  always_comb
  begin
    logic [7:0] acc;
    acc = jrxcfg_pkg::ZERO_BYTE;
    if (by_octets)
    begin
      for (int i = 0; i < jrxcfg_pkg::CFG_BYTES; i++)
        acc = acc + octet_at(cfg_octets, 4'(i));
    end
    else
    begin
      for (int f = 0; f < jrxcfg_pkg::NUM_FIELDS; f++)
        acc = acc + ((octet_at(cfg_octets, jrxcfg_pkg::FLD_OCTET[f])
                      & jrxcfg_pkg::FLD_MASK[f])
                     >> jrxcfg_pkg::FLD_SHIFT[f]);
    end
    csum = acc;
  end

endmodule : jrxcfg_csum

/* verilog/jrxcfg_regs.sv */
// register bank for the serial receiver link configuration slice
// assumes a single-cycle register port on ref_clk, read data one cycle on
//
// Local design decision: strobed register access.

`timescale 1ns/10ps

// Notes on behaviour
// - rising edge of calibration trigger calibrates lanes 2 to 5 to 50 ohm
// - checksum computed per method bit 6, stored once per link, read back at any of the per-lane sum registers
// - method 0 sums the individual link parameter fields
// - method 1 sums configuration octets 0x400..0x40A modulo 256
// - bit 3 selects single link (0) or dual link (1), resets 0
// - bit 2 directs link-specific accesses to link 0 or link 1 map
// - enable bits 1:0 bring up each link's logic, set after setup
module jrxcfg_regs
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [7:0]  reg_rdata,
  // termination control
  output      logic        term_cal_start,
  output      logic [7:0]  term_cal_lanes,
  output      logic [7:0]  term_cal_target,
  output      logic [7:0]  term_setting_a,
  output      logic [7:0]  term_setting_b,
  // link control
  output      logic        checksum_by_octets,
  output      logic        link_dual,
  output      logic        map_page_sel,
  output      logic [1:0]  link_enable
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]  term_cal_q;
  logic        trig_prev_q;
  logic        cal_start_q;
  logic [7:0]  cal_lanes_q;
  logic [7:0]  cal_target_q;
  logic [7:0]  set_a_q;
  logic [7:0]  set_b_q;
  logic [7:0]  gen_ctrl_q;
  logic [7:0]  cfg_q [0:1][0:10];
  logic [7:0]  csum_q [0:1];
  logic [7:0]  rdata_q;
  logic [87:0] cfg_flat [0:1];
  logic [7:0]  csum_d [0:1];
  logic        page;

  // ------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------

  // true inside the paged configuration octet window
  function automatic logic is_cfg(input logic [11:0] a);
    is_cfg = (a >= jrxcfg_pkg::ADDR_CFG_FIRST) &&
             (a <= jrxcfg_pkg::ADDR_CFG_LAST);
  endfunction : is_cfg

  // octet index within the configuration window
  function automatic logic [3:0] cfg_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - jrxcfg_pkg::ADDR_CFG_FIRST;
    cfg_idx = off[3:0];
  endfunction : cfg_idx

  // true on any of the per-lane computed checksum registers
  function automatic logic is_csum(input logic [11:0] a);
    logic [11:0] off;
    logic [11:0] span;
    off  = a - jrxcfg_pkg::ADDR_CSUM_FIRST;
    span = 12'(jrxcfg_pkg::CSUM_LANES) * jrxcfg_pkg::ADDR_CSUM_STEP;
    is_csum = (a >= jrxcfg_pkg::ADDR_CSUM_FIRST) && (off < span) &&
              ((off & (jrxcfg_pkg::ADDR_CSUM_STEP - 12'h001)) == 12'h000);
  endfunction : is_csum

  assign page = gen_ctrl_q[jrxcfg_pkg::PAGE_SEL_BIT];

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------

  // calibration trigger; only bit 0 is kept
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      term_cal_q <= jrxcfg_pkg::TERM_CAL_RESET;
    else if (reg_wr && reg_addr == jrxcfg_pkg::ADDR_TERM_CAL_B)
      term_cal_q <= reg_wdata & jrxcfg_pkg::TERM_CAL_MASK;
  end

  // termination settings; software must load the proper values itself
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      set_a_q <= jrxcfg_pkg::TERM_SET_A_RST;
      set_b_q <= jrxcfg_pkg::TERM_SET_B_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == jrxcfg_pkg::ADDR_TERM_SET_A)
        set_a_q <= reg_wdata;
      if (reg_addr == jrxcfg_pkg::ADDR_TERM_SET_B)
        set_b_q <= reg_wdata;
    end
  end

  // general control: method, link count, page and link enables
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gen_ctrl_q <= jrxcfg_pkg::GEN_CTRL_RESET;
    else if (reg_wr && reg_addr == jrxcfg_pkg::ADDR_GEN_CTRL)
      gen_ctrl_q <= reg_wdata & jrxcfg_pkg::GEN_CTRL_MASK;
  end

  // configuration octets, one copy per link, chosen by the page bit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int l = 0; l < jrxcfg_pkg::LINKS; l++)
        for (int i = 0; i < jrxcfg_pkg::CFG_BYTES; i++)
          cfg_q[l][i] <= jrxcfg_pkg::CFG_RESET;
    end
    else if (reg_wr && is_cfg(reg_addr))
      cfg_q[page][cfg_idx(reg_addr)] <= reg_wdata;
  end

  // ------------------------------------------------------------
  // termination calibration
  // ------------------------------------------------------------

  // edge detect on the stored bit: rewriting a 1 does not recalibrate,
  // software must clear it first to arm the next calibration
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_prev_q  <= 1'b0;
      cal_start_q  <= 1'b0;
      cal_lanes_q  <= jrxcfg_pkg::ZERO_BYTE;
      cal_target_q <= jrxcfg_pkg::ZERO_BYTE;
    end
    else
    begin
      trig_prev_q <= term_cal_q[jrxcfg_pkg::CAL_TRIG_BIT];
      cal_start_q <= term_cal_q[jrxcfg_pkg::CAL_TRIG_BIT] &
                     ~trig_prev_q;
      cal_lanes_q  <= jrxcfg_pkg::CAL_LANE_MASK;
      cal_target_q <= jrxcfg_pkg::CAL_TARGET_OHM;
    end
  end

  // ------------------------------------------------------------
  // checksum computation per link
  // ------------------------------------------------------------

  // pack each link's octets for the checksum unit
  always_comb
  begin
    for (int l = 0; l < jrxcfg_pkg::LINKS; l++)
      for (int i = 0; i < jrxcfg_pkg::CFG_BYTES; i++)
        cfg_flat[l][i*8 +: 8] = cfg_q[l][i];
  end

  jrxcfg_csum u_csum_link0
  (
    .cfg_octets (cfg_flat[0]),
    .by_octets  (gen_ctrl_q[jrxcfg_pkg::CSUM_MODE_BIT]),
    .csum       (csum_d[0])
  );

  jrxcfg_csum u_csum_link1
  (
    .cfg_octets (cfg_flat[1]),
    .by_octets  (gen_ctrl_q[jrxcfg_pkg::CSUM_MODE_BIT]),
    .csum       (csum_d[1])
  );

  // registered store keeps the adder tree off the read path
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csum_q[0] <= jrxcfg_pkg::ZERO_BYTE;
      csum_q[1] <= jrxcfg_pkg::ZERO_BYTE;
    end
    else
    begin
      csum_q[0] <= csum_d[0];
      csum_q[1] <= csum_d[1];
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------

  // unmapped addresses read zero; data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= jrxcfg_pkg::ZERO_BYTE;
    else if (reg_rd)
    begin
      if (reg_addr == jrxcfg_pkg::ADDR_TERM_CAL_B)
        rdata_q <= term_cal_q;
      else if (reg_addr == jrxcfg_pkg::ADDR_TERM_SET_A)
        rdata_q <= set_a_q;
      else if (reg_addr == jrxcfg_pkg::ADDR_TERM_SET_B)
        rdata_q <= set_b_q;
      else if (reg_addr == jrxcfg_pkg::ADDR_GEN_CTRL)
        rdata_q <= gen_ctrl_q;
      else if (is_cfg(reg_addr))
        rdata_q <= cfg_q[page][cfg_idx(reg_addr)];
      else if (is_csum(reg_addr))
        rdata_q <= csum_q[page];
      else
        rdata_q <= jrxcfg_pkg::ZERO_BYTE;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata          = rdata_q;
  assign term_cal_start     = cal_start_q;
  assign term_cal_lanes     = cal_lanes_q;
  assign term_cal_target    = cal_target_q;
  assign term_setting_a     = set_a_q;
  assign term_setting_b     = set_b_q;
  assign checksum_by_octets = gen_ctrl_q[jrxcfg_pkg::CSUM_MODE_BIT];
  assign link_dual          = gen_ctrl_q[jrxcfg_pkg::LINK_DUAL_BIT];
  assign map_page_sel       = page;
  // the enables are passed on as written; ordering is software's job
  assign link_enable        = gen_ctrl_q[jrxcfg_pkg::LINK_EN_MSB:
                                         jrxcfg_pkg::LINK_EN_LSB];

endmodule : jrxcfg_regs
